// File: verilog/eepc_pkg.sv
/*
  Constants and types for the EEPROM program/erase control block:
  register byte addresses, bit positions, reset values, array bounds,
  protect region bounds and the erase-size and bus-state encodings.
  Assumes a 16-bit byte address space and a 32-bit APB data path.
*/
package eepc_pkg;
  // Register byte addresses, one aligned APB word each
  localparam logic [15:0] ADDR_CONFIG = 16'h00F0;
  localparam logic [15:0] ADDR_PROTECT = 16'h00F4;
  localparam logic [15:0] ADDR_TEST = 16'h00F8;
  localparam logic [15:0] ADDR_PROG = 16'h00FC;
  // Array window
  localparam logic [15:0] ARRAY_FIRST = 16'h0D00;
  localparam logic [15:0] ARRAY_LAST = 16'h0FFF;
  localparam int ARRAY_BYTES = 768;
  localparam int ROW_BYTES = 32;
  // Protect region starts, highest protect bit first
  localparam logic [15:0] REGION3_FIRST = 16'h0E00;
  localparam logic [15:0] REGION2_FIRST = 16'h0F00;
  localparam logic [15:0] REGION1_FIRST = 16'h0F80;
  localparam logic [15:0] REGION0_FIRST = 16'h0FC0;
  // Config register
  localparam int CFG_WAIT_STOP = 2;
  localparam int CFG_PROT_LOCK = 1;
  localparam int CFG_PUMP_CLK = 0;
  localparam logic [7:0] CFG_FIXED_ONES = 8'hF8;
  localparam logic [7:0] CONFIG_RESET = 8'hFC;
  // Block protect register
  localparam int PROTECT_BITS = 5;
  localparam logic [4:0] PROTECT_RESET = 5'h1F;
  // Test register
  localparam int TST_ODD = 7;
  localparam int TST_EVEN = 6;
  localparam int TST_MARGIN = 5;
  localparam int TST_PUMP_OFF = 4;
  localparam int TST_RAMP_OFF = 3;
  localparam int TST_MONITOR = 2;
  localparam logic [5:0] TEST_RESET = 6'h00;
  // Program control register
  localparam int PRG_BULK_PROTECT = 7;
  localparam int PRG_BYTE = 4;
  localparam int PRG_ROW = 3;
  localparam int PRG_ERASE = 2;
  localparam int PRG_LATCH = 1;
  localparam int PRG_PGM = 0;
  localparam logic [7:0] PROG_RESET = 8'h80;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam int MISALIGN_WAIT = 1;

  typedef enum logic [1:0] {
    EEPC_ERASE_BULK = 2'b00,
    EEPC_ERASE_ROW = 2'b01,
    EEPC_ERASE_BYTE = 2'b10
  } eepc_erase_t;

  typedef enum logic {
    EEPC_APB_READY = 1'b0,
    EEPC_APB_STALL = 1'b1
  } eepc_apb_t;
endpackage

// File: verilog/eepc_top.sv
/*
  EEPROM program/erase control: APB slave holding the four control
  registers and the 768-byte array, with address/data latches, block
  and bulk protection, test bits, pump clock choice, wait/stop gating.
  Assumes clk is the bus clock, stop_mode, wait_mode and
  array_read_enable come from logic on clk, special_mode_n is a pin.
*/
// What this block does
// R1: 768-byte array; misaligned word reads take two
// R2: Program byte or aligned word; misaligned latches low
// R3: Byte, word, row, bulk erase; erased reads ones
// R4: Control at 0xF0 block, array 0x0D00-0x0FFF
// R5: Read enable gates only array reads
// R6: Stop drops voltage and RC, keeps enable
// R7: Wait-stop bit stops module during wait
// R8: Pump clock select picks system or RC
// R9: Protect lock write-once normal, free special
// R10: Block protect writable when enable, lock clear
// R11: Five protect bits cover five array regions
// R12: Test register writable special only, else zero
// R13: Test bits: odd, even, margin, pump controls
// R14: Bulk protect refuses bulk and row erase
// R15: Byte and row bits decode erase size
// R16: Erase bit or odd/even test bit selects erase; else program
// R17: Byte erase acts on latched address, width
// R18: Latch bit captures writes, blocks array reads
// R19: Enable settable only when latch already set
// R20: Enable set freezes controls, latches, array writes
// R21: Software follows latch, write, enable, wait, clear
// R22: Software may reprogram keeping latch set
// R23: No timer; voltage held until enable clears
`timescale 1ns/10ps
module eepc_top #(
  parameter int ARRAY_BYTES = eepc_pkg::ARRAY_BYTES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode_n,
  input wire logic array_read_enable,
  input wire logic stop_mode,
  input wire logic wait_mode,
  output logic pump_hv_on,
  output logic pump_clk_sel,
  output logic rc_osc_on,
  output logic module_clk_stop,
  output logic margin_test,
  output logic pump_disable,
  output logic pump_ramp_disable,
  output logic pump_monitor
);
  localparam int WORDS = ARRAY_BYTES / 2;

  initial
  begin
    if (ARRAY_BYTES != eepc_pkg::ARRAY_BYTES)
      $error("eepc_top: array size must match the address window");
  end

  logic [1:0] rst_pipe_q;
  logic rst_n_int;
  logic smode_meta_q;
  logic smode_q;
  logic special;
  logic [15:0] mem [WORDS];
  logic [31:0] prdata_q;
  logic err_q;
  eepc_pkg::eepc_apb_t apb_q;
  logic wait_stop_q;
  logic prot_lock_q;
  logic lock_used_q;
  logic pump_clk_q;
  logic [4:0] bprot_q;
  logic [5:0] test_q;
  logic bulk_protect_q;
  logic byte_q;
  logic row_q;
  logic erase_q;
  logic latch_q;
  logic pgm_q;
  logic [8:0] lat_idx_q;
  logic [15:0] lat_data_q;
  logic [1:0] lat_lanes_q;
  logic access;
  logic hit_array;
  logic arr_rd_odd;
  logic wr_en;
  logic op_on;
  logic test_bulk;
  eepc_pkg::eepc_erase_t erase_sel;

  // Reset released through two flops; async assert
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_pipe_q <= 2'b00;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end
  assign rst_n_int = rst_pipe_q[1];

  // Mode pin synchroniser; second flop only is read
  always_ff @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      smode_meta_q <= 1'b1;
      smode_q <= 1'b1;
    end
    else
    begin
      smode_meta_q <= special_mode_n;
      smode_q <= smode_meta_q;
    end
  end
  assign special = !smode_q;

  function automatic logic [8:0] word_index(input logic [15:0] addr);
    logic [15:0] off;
    off = addr - eepc_pkg::ARRAY_FIRST;
    return off[9:1];
  endfunction

  function automatic logic [7:0] rd_byte(input logic [15:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    if (addr >= eepc_pkg::ARRAY_FIRST && addr <= eepc_pkg::ARRAY_LAST)
      w = mem[word_index(addr)];
    return addr[0] ? w[7:0] : w[15:8];
  endfunction

  // Word index to protect bit; higher bit, lower address
  function automatic logic is_protected(input logic [8:0] idx,
                                        input logic [4:0] bp);
    logic [15:0] a;
    a = eepc_pkg::ARRAY_FIRST + {6'h00, idx, 1'b0};
    if (a >= eepc_pkg::REGION0_FIRST)
      return bp[0];
    else if (a >= eepc_pkg::REGION1_FIRST)
      return bp[1];
    else if (a >= eepc_pkg::REGION2_FIRST)
      return bp[2];
    else if (a >= eepc_pkg::REGION3_FIRST)
      return bp[3];
    return bp[4]; // see R11
  endfunction

  function automatic logic [4:0] row_of(input logic [8:0] idx);
    return idx[8:4];
  endfunction

  // Byte wins over row; bulk when both clear
  function automatic eepc_pkg::eepc_erase_t decode_erase(input logic b,
                                                         input logic r);
    if (b)
      return eepc_pkg::EEPC_ERASE_BYTE;
    else if (r)
      return eepc_pkg::EEPC_ERASE_ROW;
    return eepc_pkg::EEPC_ERASE_BULK; // see R15
  endfunction

  // APB decode
  assign access = psel && penable;
  assign hit_array = (paddr >= eepc_pkg::ARRAY_FIRST) &&
                     (paddr <= eepc_pkg::ARRAY_LAST); // see R4
  assign arr_rd_odd = access && hit_array && !pwrite && paddr[0];
  // Misaligned read needs the next word too, so one stall cycle
  assign pready = !(arr_rd_odd && apb_q == eepc_pkg::EEPC_APB_READY);
  assign pslverr = access && pready && err_q;
  assign prdata = prdata_q;
  assign wr_en = access && pwrite && pready;

  always_ff @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      apb_q <= eepc_pkg::EEPC_APB_READY;
    else
    begin
      case (apb_q)
        eepc_pkg::EEPC_APB_READY:
          if (arr_rd_odd)
            apb_q <= eepc_pkg::EEPC_APB_STALL; // see R1
        eepc_pkg::EEPC_APB_STALL:
          apb_q <= eepc_pkg::EEPC_APB_READY;
        default:
          apb_q <= eepc_pkg::EEPC_APB_READY;
      endcase
    end
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
      if (paddr == eepc_pkg::ADDR_CONFIG)
        prdata_q[7:0] <= eepc_pkg::CFG_FIXED_ONES |
                         {5'h00, wait_stop_q, prot_lock_q, pump_clk_q};
      else if (paddr == eepc_pkg::ADDR_PROTECT)
        prdata_q[4:0] <= bprot_q;
      else if (paddr == eepc_pkg::ADDR_TEST)
        prdata_q[7:2] <= test_q;
      else if (paddr == eepc_pkg::ADDR_PROG)
        prdata_q[7:0] <= {bulk_protect_q, 2'b00, byte_q, row_q, erase_q,
                          latch_q, pgm_q};
      else if (hit_array && !pwrite)
      begin
        if (latch_q || !array_read_enable)
          err_q <= 1'b1; // see R5, R18
        else
          prdata_q[15:0] <= {rd_byte(paddr),
                             rd_byte(paddr + 16'h0001)}; // see R1
      end
      else if (!hit_array)
        err_q <= 1'b1;
    end
  end

  // Config register
  always_ff @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      wait_stop_q <= eepc_pkg::CONFIG_RESET[eepc_pkg::CFG_WAIT_STOP];
      prot_lock_q <= eepc_pkg::CONFIG_RESET[eepc_pkg::CFG_PROT_LOCK];
      pump_clk_q <= eepc_pkg::CONFIG_RESET[eepc_pkg::CFG_PUMP_CLK];
      lock_used_q <= 1'b0;
    end
    else if (wr_en && paddr == eepc_pkg::ADDR_CONFIG)
    begin
      wait_stop_q <= pwdata[eepc_pkg::CFG_WAIT_STOP]; // see R7
      pump_clk_q <= pwdata[eepc_pkg::CFG_PUMP_CLK]; // see R8
      if (special || !lock_used_q)
        prot_lock_q <= pwdata[eepc_pkg::CFG_PROT_LOCK]; // see R9
      if (!special)
        lock_used_q <= 1'b1; // see R9
    end
  end

  // Block protect register
  always_ff @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      bprot_q <= eepc_pkg::PROTECT_RESET;
    else if (wr_en && paddr == eepc_pkg::ADDR_PROTECT &&
             !pgm_q && !prot_lock_q)
      bprot_q <= pwdata[eepc_pkg::PROTECT_BITS-1:0]; // see R10
  end

  // Test register; held clear whenever the part is in normal mode
  always_ff @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
      test_q <= eepc_pkg::TEST_RESET;
    else if (!special)
      test_q <= eepc_pkg::TEST_RESET; // see R12
    else if (wr_en && paddr == eepc_pkg::ADDR_TEST)
      test_q <= pwdata[7:2]; // see R12
  end
  assign margin_test = test_q[eepc_pkg::TST_MARGIN-2]; // see R13
  assign pump_disable = test_q[eepc_pkg::TST_PUMP_OFF-2]; // see R13
  assign pump_ramp_disable = test_q[eepc_pkg::TST_RAMP_OFF-2];
  assign pump_monitor = test_q[eepc_pkg::TST_MONITOR-2]; // see R13

  // Program control register
  always_ff @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      bulk_protect_q <= eepc_pkg::PROG_RESET[eepc_pkg::PRG_BULK_PROTECT];
      byte_q <= eepc_pkg::PROG_RESET[eepc_pkg::PRG_BYTE];
      row_q <= eepc_pkg::PROG_RESET[eepc_pkg::PRG_ROW];
      erase_q <= eepc_pkg::PROG_RESET[eepc_pkg::PRG_ERASE];
      latch_q <= eepc_pkg::PROG_RESET[eepc_pkg::PRG_LATCH];
      pgm_q <= eepc_pkg::PROG_RESET[eepc_pkg::PRG_PGM];
    end
    else if (wr_en && paddr == eepc_pkg::ADDR_PROG)
    begin
      if (pgm_q)
      begin
        // Only enable may change; latch may drop in the same write
        pgm_q <= pwdata[eepc_pkg::PRG_PGM]; // see R20, R23
        if (!pwdata[eepc_pkg::PRG_PGM])
          latch_q <= pwdata[eepc_pkg::PRG_LATCH];
      end
      else
      begin
        if (!prot_lock_q)
          bulk_protect_q <= pwdata[eepc_pkg::PRG_BULK_PROTECT]; // see R14
        byte_q <= pwdata[eepc_pkg::PRG_BYTE];
        row_q <= pwdata[eepc_pkg::PRG_ROW];
        erase_q <= pwdata[eepc_pkg::PRG_ERASE]; // see R16
        latch_q <= pwdata[eepc_pkg::PRG_LATCH];
        pgm_q <= pwdata[eepc_pkg::PRG_PGM] && latch_q; // see R19
      end
    end
  end

  // Address/data latches; a misaligned word keeps its low-address byte
  always_ff @(posedge clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      lat_idx_q <= 9'h000;
      lat_data_q <= eepc_pkg::ERASED_WORD;
      lat_lanes_q <= 2'b00;
    end
    else if (wr_en && hit_array && latch_q && !pgm_q) // see R18, R20
    begin
      lat_idx_q <= word_index(paddr);
      if (pstrb[1:0] == 2'b11 && !paddr[0])
      begin
        lat_data_q <= pwdata[15:0];
        lat_lanes_q <= 2'b11;
      end
      else
      begin
        lat_data_q <= (pstrb[1:0] == 2'b11) ?
                      {2{pwdata[15:8]}} : {2{pwdata[7:0]}}; // see R2
        lat_lanes_q <= paddr[0] ? 2'b01 : 2'b10; // see R2, R17
      end
    end
  end

  // Voltage follows the enable bit, cut while stop or the wait gating is active; no timer ends it
  assign module_clk_stop = wait_mode && wait_stop_q; // see R7
  assign pump_hv_on = pgm_q && !stop_mode &&
                      !module_clk_stop; // see R6, R23
  assign pump_clk_sel = pump_clk_q; // see R8
  assign rc_osc_on = pump_clk_q && !stop_mode &&
                     !module_clk_stop; // see R6, R8
  assign op_on = pump_hv_on && !pump_disable;
  assign test_bulk = test_q[eepc_pkg::TST_ODD-2] ||
                     test_q[eepc_pkg::TST_EVEN-2];
  assign erase_sel = decode_erase(byte_q, row_q);

  // Lanes of word i touched by the running operation
  function automatic logic [15:0] op_mask(input logic [8:0] i);
    logic hit;
    logic [1:0] ln;
    hit = 1'b0;
    ln = 2'b11;
    if (test_bulk)
      hit = !bulk_protect_q &&
            (row_of(i)[0] ? test_q[eepc_pkg::TST_ODD-2]
                          : test_q[eepc_pkg::TST_EVEN-2]); // see R13
    else if (!erase_q)
    begin
      hit = (i == lat_idx_q);
      ln = lat_lanes_q;
    end
    else
    begin
      case (erase_sel)
        eepc_pkg::EEPC_ERASE_BULK:
          hit = !bulk_protect_q; // see R3, R14
        eepc_pkg::EEPC_ERASE_ROW:
          hit = !bulk_protect_q &&
                (row_of(i) == row_of(lat_idx_q)); // see R3, R14
        eepc_pkg::EEPC_ERASE_BYTE:
        begin
          hit = (i == lat_idx_q); // see R17
          ln = lat_lanes_q;
        end
        default:
          hit = 1'b0;
      endcase
    end
    if (!hit || is_protected(i, bprot_q))
      return 16'h0000; // see R10
    return {{8{ln[1]}}, {8{ln[0]}}};
  endfunction

  // Array cells; nonvolatile, so not reset. Program clears bits only.
  always_ff @(posedge clk)
  begin
    if (op_on)
    begin
      for (int i = 0; i < WORDS; i++)
      begin
        if (erase_q || test_bulk)
          mem[i] <= mem[i] | op_mask(9'(i)); // see R3
        else
          mem[i] <= mem[i] & (lat_data_q | ~op_mask(9'(i))); // see R2
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_int);

  a_enable_needs_latch: assert property ( // see R19
    pgm_q |-> latch_q)
    else $error("enable set without latch");
  a_both_set_once: assert property ( // see R19
    wr_en && paddr == eepc_pkg::ADDR_PROG && !latch_q && !pgm_q &&
    pwdata[1] && pwdata[0] |=> latch_q && !pgm_q)
    else $error("enable set together with latch");
  a_latch_frozen: assert property ( // see R20
    pgm_q |=> $stable(lat_idx_q) && $stable(lat_data_q))
    else $error("latches changed during operation");
  a_protect_held: assert property ( // see R10
    pgm_q || prot_lock_q |=> $stable(bprot_q))
    else $error("protect bits changed while locked");
  a_stop_hv_off: assert property ( // see R6
    stop_mode |-> !pump_hv_on && !rc_osc_on)
    else $error("voltage on during stop");
  a_stop_keeps_enable: assert property ( // see R6
    stop_mode && pgm_q && !wr_en |=> pgm_q)
    else $error("stop cleared enable");
  a_wait_gates: assert property ( // see R7
    wait_mode && wait_stop_q |-> module_clk_stop && !pump_hv_on)
    else $error("module clocked in wait");
  a_rc_selected: assert property ( // see R8
    !pump_clk_q |-> !rc_osc_on)
    else $error("rc running while system clock chosen");
  a_test_normal: assert property ( // see R12
    !special |=> test_q == eepc_pkg::TEST_RESET)
    else $error("test bits set in normal mode");
  a_misaligned_wait: assert property ( // see R1
    arr_rd_odd && apb_q == eepc_pkg::EEPC_APB_READY |->
    !pready ##1 (pready && psel && penable))
    else $error("misaligned read not two cycles");
  a_latched_read_err: assert property ( // see R18
    access && hit_array && !pwrite && latch_q && $stable(latch_q)
    && $past(psel) && !$past(penable) |-> pslverr || !pready)
    else $error("array read while latched");

  c_program_run: cover property (op_on && !erase_q ##1 !pgm_q);
  c_bulk_erase: cover property (
    op_on && erase_q && erase_sel == eepc_pkg::EEPC_ERASE_BULK);
  c_misaligned: cover property (arr_rd_odd ##1 pready);
  c_stop_resume: cover property (pgm_q && stop_mode ##1 pump_hv_on);
endmodule

// File: bench/eepc_cpu_model.sv
/*
  Bus master model of the CPU that reaches the EEPROM control block.
  Assumes an APB slave on clk; the bench's own timeout ends any hang.
*/
`timescale 1ns/10ps
module eepc_cpu_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // Setup, access until pready, release; one idle edge between transfers
  task automatic xfer(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] rd,
    output logic err, output int wt);
    wt = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      wt++;
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data shows a changed pattern, never the last value
    pwdata <= ~d;
  endtask
endmodule

// File: bench/eeprom_program_erase_control_tb_top.sv
/*
  Self-checking bench for the EEPROM program/erase control block.
  Assumes eepc_top with its package and the CPU model alongside.
*/
`timescale 1ns/10ps
module eeprom_program_erase_control_tb_top;
  localparam logic [15:0] CFG = eepc_pkg::ADDR_CONFIG;
  localparam logic [15:0] PRT = eepc_pkg::ADDR_PROTECT;
  localparam logic [15:0] TST = eepc_pkg::ADDR_TEST;
  localparam logic [15:0] PRG = eepc_pkg::ADDR_PROG;
  localparam logic [15:0] W = 16'h0E10;
  logic clk, reset_n, special_mode_n, array_read_enable;
  logic stop_mode, wait_mode, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr, a, d;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] b;
  logic pump_hv_on, pump_clk_sel, rc_osc_on, module_clk_stop, err;
  logic margin_test, pump_disable, pump_ramp_disable, pump_monitor;
  int errors, samples_checked, cycles, wt;

  eepc_top i_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode_n(special_mode_n), .array_read_enable(array_read_enable),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .pump_hv_on(pump_hv_on),
    .pump_clk_sel(pump_clk_sel), .rc_osc_on(rc_osc_on),
    .module_clk_stop(module_clk_stop), .margin_test(margin_test),
    .pump_disable(pump_disable), .pump_ramp_disable(pump_ramp_disable),
    .pump_monitor(pump_monitor));
  eepc_cpu_model i_cpu (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Ceiling well above the roughly 1250 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] ad, input logic [31:0] dt,
    input logic [3:0] st);
    i_cpu.xfer(1'b1, ad, dt, st, rd, err, wt);
  endtask
  task automatic rdc(input logic [15:0] ad, input logic [7:0] exp);
    i_cpu.xfer(1'b0, ad, 32'h0000_0000, 4'hF, rd, err, wt);
    chk_data(rd, {24'h00_0000, exp});
    chk_bit(err, 1'b0);
  endtask
  // Array data sits in the low half of the read word
  task automatic rda(input logic [15:0] ad, input logic [15:0] exp,
    input logic eerr);
    i_cpu.xfer(1'b0, ad, 32'h0000_0000, 4'hF, rd, err, wt);
    chk_data({16'h0000, rd[15:0]}, {16'h0000, exp});
    chk_bit(err, eerr);
  endtask

  task automatic pulse(input logic [7:0] m);
    wr(PRG, {24'h00_0000, m | 8'h03}, 4'hF);
    repeat (8) @(posedge clk);
    wr(PRG, {24'h00_0000, m | 8'h02}, 4'hF);
  endtask
  task automatic pe_op(input logic [7:0] m, input logic [15:0] ad,
    input logic [15:0] dt, input logic [3:0] st);
    wr(PRG, {24'h00_0000, m | 8'h02}, 4'hF);
    wr(ad, {16'h0000, dt}, st);
    pulse(m);
    wr(PRG, 32'h0000_0000, 4'hF);
  endtask

  function automatic logic [15:0] region_first(input int i);
    case (i)
      4: return eepc_pkg::ARRAY_FIRST;
      3: return eepc_pkg::REGION3_FIRST;
      2: return eepc_pkg::REGION2_FIRST;
      1: return eepc_pkg::REGION1_FIRST;
      default: return eepc_pkg::REGION0_FIRST;
    endcase
  endfunction

  initial
  begin
    reset_n = 1'b0;
    special_mode_n = 1'b1;
    array_read_enable = 1'b1;
    stop_mode = 1'b0;
    wait_mode = 1'b0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    a = $urandom(65);
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(CFG, 8'hFC);
    rdc(PRT, 8'h1F);
    rdc(TST, 8'h00);
    rdc(PRG, 8'h80);
    rda(16'h00E0, 16'h0000, 1'b1);
    wait_mode <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk_bit(module_clk_stop, 1'b1);
    wr(CFG, 32'h0000_0001, 4'hF);
    @(posedge clk);
    chk_bit(module_clk_stop, 1'b0);
    chk_bit(rc_osc_on, 1'b1);
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk_bit(rc_osc_on, 1'b0);
    stop_mode <= 1'b0;
    wr(CFG, 32'h0000_0002, 4'hF);
    rdc(CFG, 8'hF8);
    chk_bit(pump_clk_sel, 1'b0);
    wr(PRT, 32'h0000_0000, 4'hF);
    rdc(PRT, 8'h00);
    pe_op(8'h04, eepc_pkg::ARRAY_FIRST, 16'h0000, 4'h3);
    rda(eepc_pkg::ARRAY_LAST - 16'h0001, 16'hFFFF, 1'b0);
    rda(W, 16'hFFFF, 1'b0);
    repeat (6)
    begin
      a = eepc_pkg::ARRAY_FIRST + 16'(($urandom % 384) * 2);
      d = $urandom;
      b = $urandom;
      pe_op(8'h18, a, d, 4'h3);
      rda(a, d, 1'b0);
      pe_op(8'h00, a + 16'h0001, {8'h00, b}, 4'h1);
      rda(a, {d[15:8], d[7:0] & b}, 1'b0);
      pe_op(8'h14, a, 16'h0000, 4'h1);
      rda(a, {8'hFF, d[7:0] & b}, 1'b0);
      pe_op(8'h14, a, 16'h0000, 4'h3);
      rda(a, 16'hFFFF, 1'b0);
    end
    wr(PRG, 32'h0000_0002, 4'hF);
    wr(W, 32'h0000_1234, 4'h3);
    pulse(8'h00);
    wr(W + 16'h0002, 32'h0000_5678, 4'h3);
    pulse(8'h00);
    wr(PRG, 32'h0000_0000, 4'hF);
    rda(W + 16'h0001, 16'h3456, 1'b0);
    chk_data(32'(wt), 32'(eepc_pkg::MISALIGN_WAIT));
    pe_op(8'h00, W + 16'h0001, 16'h0F00, 4'h3);
    rda(W, 16'h1204, 1'b0);
    chk_data(32'(wt), 32'h0000_0000);
    rda(W + 16'h0002, 16'h5678, 1'b0);
    wr(PRG, 32'h0000_0003, 4'hF);
    rdc(PRG, 8'h02);
    rda(W, 16'h0000, 1'b1);
    wr(W, 32'h0000_1234, 4'h3);
    wr(PRG, 32'h0000_0003, 4'hF);
    wr(W, 32'h0000_0000, 4'h3);
    wr(PRG, 32'h0000_001F, 4'hF);
    rdc(PRG, 8'h03);
    chk_bit(pump_hv_on, 1'b1);
    stop_mode <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk_bit(pump_hv_on, 1'b0);
    rdc(PRG, 8'h03);
    stop_mode <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk_bit(pump_hv_on, 1'b1);
    wr(PRG, 32'h0000_0000, 4'hF);
    @(posedge clk);
    chk_bit(pump_hv_on, 1'b0);
    rda(W, 16'h1204, 1'b0);
    array_read_enable <= 1'b0;
    rda(W, 16'h0000, 1'b1);
    pe_op(8'h00, W + 16'h0002, 16'h00FF, 4'h3);
    array_read_enable <= 1'b1;
    rda(W + 16'h0002, 16'h0078, 1'b0);
    pe_op(8'h8C, W, 16'h0000, 4'h3);
    rda(W, 16'h1204, 1'b0);
    pe_op(8'h0C, W, 16'h0000, 4'h3);
    rda(W + 16'h0002, 16'hFFFF, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      wr(PRT, 32'(1 << i), 4'hF);
      pe_op(8'h00, region_first(i), 16'h0000, 4'h3);
      rda(region_first(i), 16'hFFFF, 1'b0);
      wr(PRT, 32'(~(1 << i) & 5'h1F), 4'hF);
      pe_op(8'h00, region_first(i), 16'h0000, 4'h3);
      rda(region_first(i), 16'h0000, 1'b0);
    end
    special_mode_n <= 1'b0;
    repeat (6) @(posedge clk);
    wr(TST, 32'h0000_00FC, 4'hF);
    rdc(TST, 8'hFC);
    chk_bit(margin_test & pump_disable & pump_monitor, 1'b1);
    chk_bit(pump_ramp_disable, 1'b1);
    wr(CFG, 32'h0000_0002, 4'hF);
    wr(PRT, 32'h0000_001F, 4'hF);
    rdc(PRT, 8'h0F);
    wr(CFG, 32'h0000_0000, 4'hF);
    rdc(CFG, 8'hF8);
    special_mode_n <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(TST, 8'h00);
    end_sim();
  end
endmodule
